//--- src/mpat_pkg.sv
// Package with constants and types for the microport access timing block.
package mpat_pkg;

  // Port widths.
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int WIDE_W = 18;

  // Mode select levels.
  localparam logic MODE_READY = 1'b0;
  localparam logic MODE_ACK = 1'b1;

  // Address that holds both control registers and coefficient RAM.
  localparam logic [ADDR_W-1:0] ADDR_SHARED = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_MEDIUM = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_ACK_MED = 3'h5;

  // Access intervals in device clock periods, strobe-and-ready mode.
  localparam int RDY_FAST_CLK = 3;
  localparam int RDY_MED_CLK = 4;
  localparam int RDY_SLOW_CLK = 5;

  // Access intervals in device clock periods, strobe-and-acknowledge mode.
  localparam int ACK_FAST_CLK = 4;
  localparam int ACK_MED_CLK = 5;
  localparam int ACK_SLOW_CLK = 6;

  // Countdown width; the load value is the interval minus two.
  localparam int CNT_W = 3;

  // Reset values.
  localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;
  localparam logic [WIDE_W-1:0] WIDE_RST = 18'h00000;
  localparam logic [CNT_W-1:0] CNT_RST = 3'h0;

  // Latency class of an access.
  typedef enum logic [1:0] {
    MPAT_FAST,
    MPAT_MEDIUM,
    MPAT_SLOW
  } mpat_class_t;

  // Request handed to the core register file.
  typedef struct packed {
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mpat_core_req_t;

endpackage

//--- src/mpat_microport.sv
// Microport handshake timing and wideband output drive of the transmit processor.
// Behaviour
// [R01] Ready mode: addresses 7,6,5,3,2,1 finish with ready within three clock periods.
// [R02] Ready mode: address 4 and control accesses at address 0 finish within four periods.
// [R03] Ready mode: coefficient RAM accesses at address 0 finish within five periods.
// [R04] Acknowledge mode: addresses 7,6,3,2,1 are acknowledged within four periods.
// [R05] Acknowledge mode: addresses 4,5 and control accesses at 0 are acknowledged in five.
// [R06] Acknowledge mode: coefficient RAM accesses at address 0 are acknowledged in six.
// [R07] Ready mode counts from the strobe falling edge to ready rising, varying with address.
// [R08] Acknowledge mode counts from the data strobe falling edge to acknowledge falling.
// [R09] The wideband bus is driven only while its enable is high, floating otherwise.
// [R10] In complex output mode the Q flag marks quadrature output words.
// [R11] Mode select high picks acknowledge mode, low picks ready mode.
// [R12] The ready/acknowledge line is open drain and only ever pulls low.
// [R13] The shared strobe is a read strobe in ready mode and a data strobe in acknowledge mode.
// [R14] Strobes are ignored while chip select is inactive.
// [R15] The host holds address, data and strobe until completion before a new access.
// [R16] An access at address 0 is sorted into control or RAM before its count is chosen.
`timescale 1ns/1ps

module mpat_microport (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Host microport pins.
  input wire logic i_mode,
  input wire logic i_cs_n,
  input wire logic i_data_strobe_n,
  input wire logic i_wr_rw,
  input wire logic [mpat_pkg::ADDR_W-1:0] i_addr,
  input wire logic [mpat_pkg::DATA_W-1:0] i_data,
  output logic [mpat_pkg::DATA_W-1:0] o_data,
  output logic o_data_oe,
  output logic o_xfer_ack_n,
  output logic o_xfer_ack_n_oe,
  // Core register file side.
  input wire logic i_coef_ram_sel,
  input wire logic [mpat_pkg::DATA_W-1:0] i_core_rdata,
  output mpat_pkg::mpat_core_req_t o_core,
  // Wideband output.
  input wire logic i_wide_out_enable,
  input wire logic i_complex_mode,
  input wire logic i_wide_is_q,
  input wire logic [mpat_pkg::WIDE_W-1:0] i_wide_data,
  output logic [mpat_pkg::WIDE_W-1:0] o_wide_data,
  output logic o_wide_data_oe,
  output logic o_quad_out_flag,
  output logic o_quad_out_flag_oe
);

  typedef enum logic [1:0] {
    MPAT_IDLE,
    MPAT_WAIT,
    MPAT_DONE
  } mpat_state_t;

  mpat_state_t state_r;
  mpat_state_t state_nxt;
  logic [mpat_pkg::CNT_W-1:0] cnt_r;
  logic [mpat_pkg::CNT_W-1:0] cnt_nxt;
  mpat_pkg::mpat_class_t class_now;
  logic ack_mode_r;
  logic ack_mode_nxt;
  logic read_r;
  logic read_nxt;
  logic [mpat_pkg::DATA_W-1:0] rdata_r;
  logic [mpat_pkg::DATA_W-1:0] rdata_nxt;
  mpat_pkg::mpat_core_req_t core_r;
  mpat_pkg::mpat_core_req_t core_nxt;
  logic strobe_on;
  logic is_write;
  logic start;
  logic [mpat_pkg::CNT_W-1:0] load_val;

  // Strobe decode; in ready mode either strobe opens an access, in acknowledge
  // mode only the data strobe does and the second line gives the direction.
  always_comb
  begin
    if (i_mode == mpat_pkg::MODE_ACK) // [R11]
    begin
      strobe_on = !i_data_strobe_n; // [R13]
      is_write = !i_wr_rw;
    end
    else
    begin
      strobe_on = !i_data_strobe_n || !i_wr_rw; // [R13]
      is_write = !i_wr_rw;
    end
    start = (state_r == MPAT_IDLE) && strobe_on && !i_cs_n; // [R14]
  end

  // Latency class from address and from the control/RAM split at address 0.
  always_comb
  begin
    class_now = mpat_pkg::MPAT_FAST;
    if (i_addr == mpat_pkg::ADDR_SHARED)
    begin
      class_now = i_coef_ram_sel ? mpat_pkg::MPAT_SLOW : mpat_pkg::MPAT_MEDIUM; // [R16]
    end
    else if (i_addr == mpat_pkg::ADDR_MEDIUM)
    begin
      class_now = mpat_pkg::MPAT_MEDIUM; // [R02] [R05]
    end
    else if (i_addr == mpat_pkg::ADDR_ACK_MED && i_mode == mpat_pkg::MODE_ACK)
    begin
      class_now = mpat_pkg::MPAT_MEDIUM; // [R05]
    end
  end

  // Countdown load: interval minus two, so completion shows one period before
  // the limit measured from the edge that saw the strobe.
  always_comb
  begin
    load_val = mpat_pkg::CNT_W'(mpat_pkg::RDY_FAST_CLK - 2); // [R01]
    if (i_mode == mpat_pkg::MODE_ACK)
    begin
      case (class_now)
        mpat_pkg::MPAT_FAST: load_val = mpat_pkg::CNT_W'(mpat_pkg::ACK_FAST_CLK - 2); // [R04]
        mpat_pkg::MPAT_MEDIUM: load_val = mpat_pkg::CNT_W'(mpat_pkg::ACK_MED_CLK - 2); // [R05]
        mpat_pkg::MPAT_SLOW: load_val = mpat_pkg::CNT_W'(mpat_pkg::ACK_SLOW_CLK - 2); // [R06]
        default: load_val = mpat_pkg::CNT_W'(mpat_pkg::ACK_SLOW_CLK - 2);
      endcase
    end
    else
    begin
      case (class_now)
        mpat_pkg::MPAT_FAST: load_val = mpat_pkg::CNT_W'(mpat_pkg::RDY_FAST_CLK - 2); // [R01]
        mpat_pkg::MPAT_MEDIUM: load_val = mpat_pkg::CNT_W'(mpat_pkg::RDY_MED_CLK - 2); // [R02]
        mpat_pkg::MPAT_SLOW: load_val = mpat_pkg::CNT_W'(mpat_pkg::RDY_SLOW_CLK - 2); // [R03]
        default: load_val = mpat_pkg::CNT_W'(mpat_pkg::RDY_SLOW_CLK - 2);
      endcase
    end
  end

  // Access sequencer next state. The host keeps its pins still until the
  // completion indication, so the address is only sampled at the start.
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    ack_mode_nxt = ack_mode_r;
    read_nxt = read_r;
    rdata_nxt = rdata_r;
    core_nxt = core_r;
    core_nxt.req = 1'b0;
    case (state_r)
      MPAT_IDLE:
      begin
        if (start) // [R15]
        begin
          state_nxt = MPAT_WAIT;
          cnt_nxt = load_val; // [R07] [R08]
          ack_mode_nxt = i_mode;
          read_nxt = !is_write;
          core_nxt.req = 1'b1;
          core_nxt.we = is_write;
          core_nxt.addr = i_addr;
          core_nxt.wdata = i_data;
        end
      end
      MPAT_WAIT:
      begin
        if (cnt_r == mpat_pkg::CNT_RST)
        begin
          state_nxt = MPAT_DONE;
          rdata_nxt = i_core_rdata;
        end
        else
        begin
          cnt_nxt = cnt_r - 3'h1;
        end
      end
      MPAT_DONE:
      begin
        // Holding here until the strobe lifts stops one long strobe counting twice.
        if (!strobe_on)
        begin
          state_nxt = MPAT_IDLE;
        end
      end
      default: state_nxt = MPAT_IDLE;
    endcase
  end

  // Access sequencer registers.
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_r <= MPAT_IDLE;
      cnt_r <= mpat_pkg::CNT_RST;
      ack_mode_r <= mpat_pkg::MODE_READY;
      read_r <= 1'b0;
      rdata_r <= mpat_pkg::RDATA_RST;
      core_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      ack_mode_r <= ack_mode_nxt;
      read_r <= read_nxt;
      rdata_r <= rdata_nxt;
      core_r <= core_nxt;
    end
  end

  // Open-drain handshake line: it only pulls low. In ready mode it is low while
  // busy and released at completion; in acknowledge mode it pulls low at completion.
  always_comb
  begin
    o_xfer_ack_n = 1'b0; // [R12]
    if (ack_mode_r == mpat_pkg::MODE_ACK)
    begin
      o_xfer_ack_n_oe = (state_r == MPAT_DONE); // [R08]
    end
    else
    begin
      o_xfer_ack_n_oe = (state_r == MPAT_WAIT); // [R07]
    end
  end

  // Read data goes onto the bus only after completion and while still selected.
  assign o_data = rdata_r;
  assign o_data_oe = (state_r == MPAT_DONE) && read_r && !i_cs_n && strobe_on;
  assign o_core = core_r;

  // Wideband output path; the enable is a level taken straight from its pin.
  logic [mpat_pkg::WIDE_W-1:0] wide_r;
  logic [mpat_pkg::WIDE_W-1:0] wide_nxt;
  logic quad_r;
  logic quad_nxt;

  // Next wideband word and its Q marker.
  always_comb
  begin
    wide_nxt = i_wide_data;
    quad_nxt = i_complex_mode && i_wide_is_q; // [R10]
  end

  // Wideband registers.
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wide_r <= mpat_pkg::WIDE_RST;
      quad_r <= 1'b0;
    end
    else
    begin
      wide_r <= wide_nxt;
      quad_r <= quad_nxt;
    end
  end

  // Output drivers float together with the data word when disabled.
  assign o_wide_data = wide_r;
  assign o_wide_data_oe = i_wide_out_enable; // [R09]
  assign o_quad_out_flag = quad_r;
  assign o_quad_out_flag_oe = i_wide_out_enable; // [R09]

  // Checks on the sequencer and output drive.
  chk_rdy_fast_lat: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [R01]
    start && i_mode == 1'b0 && class_now == mpat_pkg::MPAT_FAST
    |-> ##2 state_r == MPAT_WAIT ##1 state_r == MPAT_DONE)
    else $error("ready mode fast access not done in three periods");
  chk_rdy_med_lat: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [R02]
    start && i_mode == 1'b0 && class_now == mpat_pkg::MPAT_MEDIUM
    |-> ##3 state_r == MPAT_WAIT ##1 state_r == MPAT_DONE)
    else $error("ready mode medium access timing wrong");
  chk_rdy_slow_lat: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [R03]
    start && i_mode == 1'b0 && class_now == mpat_pkg::MPAT_SLOW
    |-> (state_nxt == MPAT_WAIT) ##1 (state_r == MPAT_WAIT) [*4] ##1 state_r == MPAT_DONE)
    else $error("ready mode slow access timing wrong");
  chk_ack_fast_lat: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [R04]
    start && i_mode == 1'b1 && class_now == mpat_pkg::MPAT_FAST
    |-> ##4 o_xfer_ack_n_oe && !$past(o_xfer_ack_n_oe))
    else $error("acknowledge mode fast access timing wrong");
  chk_ack_med_lat: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [R05]
    start && i_mode == 1'b1 && class_now == mpat_pkg::MPAT_MEDIUM
    |-> !o_xfer_ack_n_oe [*5] ##1 o_xfer_ack_n_oe)
    else $error("acknowledge mode medium access timing wrong");
  chk_ack_slow_lat: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [R06]
    start && i_mode == 1'b1 && class_now == mpat_pkg::MPAT_SLOW
    |-> ##6 o_xfer_ack_n_oe && $past(state_r, 2) == MPAT_WAIT)
    else $error("acknowledge mode slow access timing wrong");
  chk_rdy_busy_low: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [R07]
    start && i_mode == 1'b0 |=> o_xfer_ack_n_oe && o_xfer_ack_n == 1'b0)
    else $error("ready line not pulled low during access");
  chk_cs_ignore: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [R14]
    state_r == MPAT_IDLE && i_cs_n |=> state_r == MPAT_IDLE && !o_core.req)
    else $error("access started without chip select");
  chk_quad_flag: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [R10]
    i_complex_mode && i_wide_is_q |=> o_quad_out_flag && o_wide_data == $past(i_wide_data))
    else $error("Q flag missing on quadrature word");
  chk_wide_float: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [R09]
    !i_wide_out_enable |-> !o_wide_data_oe && !o_quad_out_flag_oe)
    else $error("wideband bus driven while disabled");

endmodule

//--- tb/mpat_host_model.sv
// Host processor model that runs microport accesses and resolves the shared lines.
`timescale 1ns/1ps

module mpat_host_model (
  // Clock and mode.
  input wire logic i_mclk,
  input wire logic i_mode,
  // Device side of the port.
  input wire logic [mpat_pkg::DATA_W-1:0] i_data,
  input wire logic i_data_oe,
  input wire logic i_ack_n,
  input wire logic i_ack_n_oe,
  input wire mpat_pkg::mpat_core_req_t i_core,
  // Host drives and resolved lines.
  output logic o_cs_n,
  output logic o_strobe_n,
  output logic o_wr_rw,
  output logic [mpat_pkg::ADDR_W-1:0] o_addr,
  output logic [mpat_pkg::DATA_W-1:0] o_bus,
  output logic o_line_n
);
  logic host_drv = 1'b0;
  logic [mpat_pkg::DATA_W-1:0] host_val = 8'h00;

  // The external pull-up holds the line high unless the device pulls it low.
  assign o_line_n = i_ack_n_oe ? i_ack_n : 1'b1;
  // A released data bus shows the inverse of the last value, so stale data never matches.
  assign o_bus = i_data_oe ? i_data : (host_drv ? host_val : ~host_val);

  initial
  begin
    o_cs_n = 1'b1;
    o_strobe_n = 1'b1;
    o_wr_rw = 1'b1;
    o_addr = 3'h0;
  end

  // One access: strobes fall at a falling edge and are counted in whole periods.
  task automatic access(input logic rd, input logic [mpat_pkg::ADDR_W-1:0] a,
      input logic [mpat_pkg::DATA_W-1:0] wd, output int cyc, output logic line1,
      output mpat_pkg::mpat_core_req_t c1, output logic req2,
      output logic [mpat_pkg::DATA_W-1:0] rdat, output logic doe);
    cyc = 99;
    rdat = 8'h00;
    doe = 1'b0;
    o_cs_n = 1'b0;
    o_addr = a;
    host_val = wd;
    host_drv = !rd;
    o_strobe_n = !(i_mode || rd);
    o_wr_rw = rd;
    for (int j = 1; j <= 12 && cyc == 99; j++)
    begin
      @(negedge i_mclk);
      if (j == 1) c1 = i_core;
      if (j == 1) line1 = o_line_n;
      if (j == 2) req2 = i_core.req;
      if (i_mode ? o_line_n === 1'b0 : o_line_n === 1'b1)
      begin
        cyc = j;
        rdat = i_data;
        doe = i_data_oe;
      end
    end
    // Everything stays put until the edge that samples completion has passed.
    @(negedge i_mclk);
    o_strobe_n = 1'b1;
    o_wr_rw = 1'b1;
    o_cs_n = 1'b1;
    host_drv = 1'b0;
    repeat (2) @(negedge i_mclk);
  endtask

  // Strobes pulse with chip select high; the device must stay silent.
  task automatic ignored(output logic any_req, output logic any_low);
    any_req = 1'b0;
    any_low = 1'b0;
    o_strobe_n = 1'b0;
    o_wr_rw = 1'b0;
    repeat (8)
    begin
      @(negedge i_mclk);
      any_req = any_req | i_core.req;
      any_low = any_low | !o_line_n;
    end
    o_strobe_n = 1'b1;
    o_wr_rw = 1'b1;
    @(negedge i_mclk);
  endtask
endmodule

//--- tb/tb.sv
// Self-checking bench for microport access timing and the wideband output drive.
`timescale 1ns/1ps

module tb;
  typedef struct packed {
    logic mode;
    logic rd;
    logic [2:0] addr;
    logic ram;
    logic [3:0] n;
  } mpat_row_t;

  // Mode, read, address, RAM target, expected periods from strobe to completion.
  localparam mpat_row_t ROWS [18] = '{
    '{1'b0, 1'b0, 3'h1, 1'b0, 4'h3}, '{1'b0, 1'b1, 3'h2, 1'b0, 4'h3},
    '{1'b0, 1'b0, 3'h3, 1'b0, 4'h3}, '{1'b0, 1'b1, 3'h5, 1'b0, 4'h3},
    '{1'b0, 1'b0, 3'h6, 1'b0, 4'h3}, '{1'b0, 1'b1, 3'h7, 1'b0, 4'h3},
    '{1'b0, 1'b0, 3'h4, 1'b0, 4'h4}, '{1'b0, 1'b1, 3'h0, 1'b0, 4'h4},
    '{1'b0, 1'b0, 3'h0, 1'b1, 4'h5}, '{1'b1, 1'b1, 3'h1, 1'b0, 4'h4},
    '{1'b1, 1'b0, 3'h2, 1'b0, 4'h4}, '{1'b1, 1'b1, 3'h3, 1'b0, 4'h4},
    '{1'b1, 1'b0, 3'h6, 1'b0, 4'h4}, '{1'b1, 1'b1, 3'h7, 1'b0, 4'h4},
    '{1'b1, 1'b0, 3'h4, 1'b0, 4'h5}, '{1'b1, 1'b1, 3'h5, 1'b0, 4'h5},
    '{1'b1, 1'b0, 3'h0, 1'b0, 4'h5}, '{1'b1, 1'b1, 3'h0, 1'b1, 4'h6}
  };

  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic mode = 1'b0;
  logic coef_sel = 1'b0;
  logic [7:0] core_rdata = 8'h00;
  logic wen = 1'b1;
  logic cplx = 1'b0;
  logic isq = 1'b0;
  logic [17:0] wdat = 18'h00000;
  logic cs_n, strobe_n, wr_rw, line_n, data_oe, ack_n, ack_oe, wide_oe, flag, flag_oe;
  logic line1, req2, doe, any_req, any_low;
  logic [2:0] addr;
  logic [7:0] bus, dout, rdat;
  logic [17:0] wide;
  mpat_pkg::mpat_core_req_t core, c1;
  int cyc;
  int err_count = 0;
  int samples_checked = 0;

  // Free-running device clock at 40 MHz.
  always #12.5 i_mclk = ~i_mclk;

  mpat_microport DUT (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_mode(mode), .i_cs_n(cs_n),
    .i_data_strobe_n(strobe_n), .i_wr_rw(wr_rw), .i_addr(addr), .i_data(bus),
    .o_data(dout), .o_data_oe(data_oe), .o_xfer_ack_n(ack_n), .o_xfer_ack_n_oe(ack_oe),
    .i_coef_ram_sel(coef_sel), .i_core_rdata(core_rdata), .o_core(core),
    .i_wide_out_enable(wen), .i_complex_mode(cplx), .i_wide_is_q(isq),
    .i_wide_data(wdat), .o_wide_data(wide), .o_wide_data_oe(wide_oe),
    .o_quad_out_flag(flag), .o_quad_out_flag_oe(flag_oe));

  mpat_host_model host (.i_mclk(i_mclk), .i_mode(mode), .i_data(dout), .i_data_oe(data_oe),
    .i_ack_n(ack_n), .i_ack_n_oe(ack_oe), .i_core(core), .o_cs_n(cs_n),
    .o_strobe_n(strobe_n), .o_wr_rw(wr_rw), .o_addr(addr), .o_bus(bus), .o_line_n(line_n));

  // Case equality keeps an unknown from passing for a match.
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("Checked %0d, mismatched %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    // Reset held for 12 periods; outputs are checked while it is still low.
    repeat (12) @(negedge i_mclk);
    cmp("reset_ack_oe", 0, ack_oe);
    cmp("reset_data_oe", 0, data_oe);
    cmp("reset_req", 0, core.req);
    cmp("reset_wide_oe", 1, wide_oe);
    i_rstn = 1'b1;
    wen = 1'b0;
    // The table covers every address in both modes and both targets of address 0.
    for (int i = 0; i < 18; i++)
    begin
      mode = ROWS[i].mode;
      coef_sel = ROWS[i].ram;
      core_rdata = 8'h3c ^ 8'(i);
      host.access(ROWS[i].rd, ROWS[i].addr, 8'hc5 ^ 8'(i), cyc, line1, c1, req2, rdat, doe);
      if (cyc == 99)
      begin
        err_count++;
        final_report();
      end
      cmp("count", ROWS[i].n, cyc);
      cmp("line_after_start", ROWS[i].mode, line1);
      cmp("core_req", 1, c1.req);
      cmp("core_we", !ROWS[i].rd, c1.we);
      cmp("core_addr", ROWS[i].addr, c1.addr);
      cmp("req_pulse", 0, req2);
      if (!ROWS[i].rd) cmp("core_wdata", 8'hc5 ^ 8'(i), c1.wdata);
      cmp("data_oe", ROWS[i].rd, doe);
      if (ROWS[i].rd) cmp("rdata", core_rdata, rdat);
    end
    cmp("ack_level", 0, ack_n);
    // Strobes without chip select, in both modes.
    for (int m = 0; m < 2; m++)
    begin
      mode = m[0];
      host.ignored(any_req, any_low);
      cmp("ignored_req", 0, any_req);
      cmp("ignored_line", 0, any_low);
    end
    // Reset pulled in mid-access ends it at once and lets the line go high.
    mode = 1'b0;
    coef_sel = 1'b1;
    @(negedge i_mclk);
    fork
      host.access(1'b0, 3'h0, 8'h5a, cyc, line1, c1, req2, rdat, doe);
      begin
        repeat (2) @(negedge i_mclk);
        cmp("midrun_busy", 1, ack_oe);
        i_rstn = 1'b0;
        #1;
        cmp("midrun_ack_oe", 0, ack_oe);
        cmp("midrun_req", 0, core.req);
        repeat (2) @(negedge i_mclk);
        i_rstn = 1'b1;
      end
    join
    cmp("midrun_release", 3, cyc);
    // The port must work normally again after the second reset.
    coef_sel = 1'b0;
    host.access(1'b1, 3'h3, 8'h00, cyc, line1, c1, req2, rdat, doe);
    cmp("post_reset_count", 3, cyc);
    // Wideband drive and quadrature flag over every enable, mode and flag mix.
    for (int k = 0; k < 8; k++)
    begin
      wen = k[0];
      cplx = k[1];
      isq = k[2];
      wdat = 18'h2a5c3 ^ 18'(k);
      @(negedge i_mclk);
      cmp("wide_oe", wen, wide_oe);
      cmp("flag_oe", wen, flag_oe);
      cmp("wide_data", wdat, wide);
      cmp("quad_flag", cplx & isq, flag);
    end
    final_report();
  end
endmodule
